// [hdl/adcs_sequencer.v]
// Conversion sequencer: start delay, sampling and conversion timing with register port.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "adcs_map.vh"
module adcs_sequencer
#(
    parameter PHASE_W = 2
)
(
    input wire clk,
    input wire reset_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire external_trigger_pin,
    input wire [9:0] afe_result,
    output reg afe_sample,
    output reg afe_convert,
    output reg [2:0] afe_channel,
    output reg result_valid,
    output reg [2:0] result_channel,
    output reg conversion_end_interrupt,
    output reg irq
);
    localparam ST_IDLE = 2'b00;
    localparam ST_DELAY = 2'b01;
    localparam ST_SAMPLE = 2'b10;
    localparam ST_CONV = 2'b11;

    ////////////////////////////////////////////////////////////////////////////
    reg [2:0] chan_sel;
    reg conversion_speed_select;
    reg scan_mode;
    reg end_interrupt_enable;
    reg conversion_start_flag;
    reg conversion_end_flag;
    reg trigger_input_enable;
    reg [`ADCS_EVT_W-1:0] irq_status;
    reg [`ADCS_EVT_W-1:0] irq_mask;
    reg [9:0] last_result;
    reg [1:0] state;
    reg [7:0] count;
    reg [PHASE_W-1:0] phase;
    reg first_conv;
    reg [2:0] cur_chan;
    wire trig_fall;
    wire trig_start;
    wire sw_start;
    wire conv_done;
    wire group_last;

    adcs_trig_sync u_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .pin_n(external_trigger_pin),
        .fall(trig_fall)
    );

    // Conversion phase of a later scan conversion: fixed repeat length minus sampling.
    function [7:0] conv_len;
        input spd;
        begin
            if (spd)
                conv_len = `ADCS_SCAN1 - `ADCS_SPL1;
            else
                conv_len = `ADCS_SCAN0 - `ADCS_SPL0;
        end
    endfunction

    // Conversion phase of the first conversion after a start: the total then runs
    // from the minimum total up by the same stretch as the start delay.
    function [7:0] first_len;
        input spd;
        begin
            if (spd)
                first_len = `ADCS_TOT1_MIN - `ADCS_DLY1_MIN - `ADCS_SPL1;
            else
                first_len = `ADCS_TOT0_MIN - `ADCS_DLY0_MIN - `ADCS_SPL0;
        end
    endfunction

    function [7:0] spl_len;
        input spd;
        begin
            spl_len = spd ? `ADCS_SPL1 : `ADCS_SPL0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign trig_start = trig_fall & trigger_input_enable;
    assign sw_start = wr && (addr == `ADCS_ADDR_CSR) && wdata[`ADCS_CSR_START];
    assign conv_done = (state == ST_CONV) && (count == `ADCS_ONE8);
    assign group_last = ~scan_mode || (cur_chan[1:0] == chan_sel[1:0]);

    // Free-running phase counter; a start lands at a random phase of it, so the
    // delay stretches by 0..3 states (speed 0) or 0..1 state (speed 1).
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            phase <= {PHASE_W{1'b0}};
        else
            phase <= phase + {{(PHASE_W-1){1'b0}}, 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            count <= `ADCS_ZERO8;
            first_conv <= 1'b0;
            cur_chan <= 3'h0;
            afe_sample <= 1'b0;
            afe_convert <= 1'b0;
            afe_channel <= 3'h0;
            result_valid <= 1'b0;
            result_channel <= 3'h0;
            last_result <= 10'h000;
        end
        else
        begin
            result_valid <= 1'b0;
            if (!conversion_start_flag)
            begin
                state <= ST_IDLE;
                afe_sample <= 1'b0;
                afe_convert <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        // Delay: 6 + phase(0..3) or 4 + phase(0..1).
                        state <= ST_DELAY;
                        first_conv <= 1'b1;
                        cur_chan <= scan_mode ? {chan_sel[2], 2'b00} : chan_sel;
                        if (conversion_speed_select)
                            count <= `ADCS_DLY1_MIN - `ADCS_TWO8 + {7'h00, phase[0]};
                        else
                            count <= `ADCS_DLY0_MIN - `ADCS_TWO8 + {6'h00, phase[1:0]};
                    end
                    ST_DELAY:
                    begin
                        if (count == `ADCS_ZERO8)
                        begin
                            state <= ST_SAMPLE;
                            afe_sample <= 1'b1;
                            afe_channel <= cur_chan;
                            count <= spl_len(conversion_speed_select);
                        end
                        else
                            count <= count - `ADCS_ONE8;
                    end
                    ST_SAMPLE:
                    begin
                        if (count == `ADCS_ONE8)
                        begin
                            state <= ST_CONV;
                            afe_sample <= 1'b0;
                            afe_convert <= 1'b1;
                            if (first_conv)
                                count <= first_len(conversion_speed_select);
                            else
                                count <= conv_len(conversion_speed_select);
                        end
                        else
                            count <= count - `ADCS_ONE8;
                    end
                    ST_CONV:
                    begin
                        if (conv_done)
                        begin
                            afe_convert <= 1'b0;
                            result_valid <= 1'b1;
                            result_channel <= cur_chan;
                            last_result <= afe_result;
                            first_conv <= 1'b0;
                            if (scan_mode)
                            begin
                                // Later scan conversions: fixed 128 / 66 states.
                                state <= ST_SAMPLE;
                                afe_sample <= 1'b1;
                                cur_chan <= group_last ? {chan_sel[2], 2'b00} : cur_chan + 3'h1;
                                afe_channel <= group_last ? {chan_sel[2], 2'b00} : cur_chan + 3'h1;
                                count <= spl_len(conversion_speed_select);
                            end
                            else
                                state <= ST_IDLE;
                        end
                        else
                            count <= count - `ADCS_ONE8;
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers and flags; hardware set wins over software clear.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chan_sel <= 3'h0;
            conversion_speed_select <= 1'b0;
            scan_mode <= 1'b0;
            end_interrupt_enable <= 1'b0;
            conversion_start_flag <= 1'b0;
            conversion_end_flag <= 1'b0;
            trigger_input_enable <= 1'b0;
            irq_status <= {`ADCS_EVT_W{1'b0}};
            irq_mask <= {`ADCS_EVT_W{1'b0}};
        end
        else
        begin
            if (wr && addr == `ADCS_ADDR_CSR)
            begin
                chan_sel <= wdata[`ADCS_CSR_CH_MSB:`ADCS_CSR_CH_LSB];
                conversion_speed_select <= wdata[`ADCS_CSR_SPEED];
                scan_mode <= wdata[`ADCS_CSR_SCAN];
                end_interrupt_enable <= wdata[`ADCS_CSR_IE];
                conversion_start_flag <= wdata[`ADCS_CSR_START];
                if (!wdata[`ADCS_CSR_END])
                    conversion_end_flag <= 1'b0;
            end
            if (wr && addr == `ADCS_ADDR_TRG)
                trigger_input_enable <= wdata[`ADCS_TRG_EN];
            if (wr && addr == `ADCS_ADDR_MASK)
                irq_mask <= wdata[`ADCS_EVT_W-1:0];
            if (conv_done && group_last)
            begin
                conversion_end_flag <= 1'b1;
                if (!scan_mode && !sw_start)
                    conversion_start_flag <= 1'b0;
            end
            // A trigger edge in the completion cycle must not be lost to the auto-clear.
            if (trig_start)
                conversion_start_flag <= 1'b1;
            if (rd && addr == `ADCS_ADDR_STAT)
                irq_status <= {`ADCS_EVT_W{1'b0}};
            if (conv_done && group_last)
                irq_status[`ADCS_ST_END] <= 1'b1;
            if (trig_start)
                irq_status[`ADCS_ST_TRIG] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port and interrupt outputs.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= 32'h00000000;
            irq <= 1'b0;
            conversion_end_interrupt <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status & irq_mask);
            conversion_end_interrupt <= conversion_end_flag & end_interrupt_enable;
            rdata <= 32'h00000000;
            if (rd)
            begin
                case (addr)
                    `ADCS_ADDR_CSR:
                        rdata <= {24'h000000, conversion_end_flag, conversion_start_flag,
                                  end_interrupt_enable, scan_mode, conversion_speed_select,
                                  chan_sel};
                    `ADCS_ADDR_TRG:
                        rdata <= {24'h000000, trigger_input_enable, 7'h00} | `ADCS_TRG_RSVD;
                    `ADCS_ADDR_STAT:
                        rdata <= {30'h00000000, irq_status};
                    `ADCS_ADDR_MASK:
                        rdata <= {30'h00000000, irq_mask};
                    `ADCS_ADDR_RES:
                        rdata <= {18'h00000, first_conv, cur_chan, last_result[9:0]};
                    default:
                        rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [common/adcs_map.vh]
// Register map, field positions, reserved-bit read value and phase lengths of the conversion sequencer.
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH
// Register addresses (byte offsets, one 32-bit word each).
`define ADCS_ADDR_CSR 8'h00
`define ADCS_ADDR_TRG 8'h04
`define ADCS_ADDR_STAT 8'h08
`define ADCS_ADDR_MASK 8'h0C
`define ADCS_ADDR_RES 8'h10
// Control/status register fields and the trigger-register enable bit.
`define ADCS_CSR_CH_LSB 0
`define ADCS_CSR_CH_MSB 2
`define ADCS_CSR_SPEED 3
`define ADCS_CSR_SCAN 4
`define ADCS_CSR_IE 5
`define ADCS_CSR_START 6
`define ADCS_CSR_END 7
`define ADCS_TRG_EN 7
// Reserved trigger-register bits 6..1 read as one.
`define ADCS_TRG_RSVD 32'h0000007E
// Status / mask bits.
`define ADCS_ST_END 0
`define ADCS_ST_TRIG 1
`define ADCS_EVT_W 2
// Phase lengths in clock states.
`define ADCS_DLY0_MIN 8'h06
`define ADCS_DLY1_MIN 8'h04
`define ADCS_SPL0 8'h1F
`define ADCS_SPL1 8'h0F
// Fixed scan-repeat conversion lengths; successive-approximation part follows.
`define ADCS_SCAN0 8'h80
`define ADCS_SCAN1 8'h42
// Minimum single-conversion totals; the first conversion phase is what remains.
`define ADCS_TOT0_MIN 8'h83
`define ADCS_TOT1_MIN 8'h45
`define ADCS_ZERO8 8'h00
`define ADCS_ONE8 8'h01
`define ADCS_TWO8 8'h02
`endif

// [hdl/adcs_trig_sync.v]
// Synchroniser and falling-edge detector for the external trigger pin.
`timescale 1ns/10ps
`default_nettype none
module adcs_trig_sync
(
    input wire clk,
    input wire reset_n,
    input wire pin_n,
    output reg fall
);
    reg meta;
    reg sync;
    reg last;

    // Two flip-flops before the edge detector; the pin idles high.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
            fall <= 1'b0;
        end
        else
        begin
            meta <= pin_n;
            sync <= meta;
            last <= sync;
            fall <= last & ~sync;
        end
    end
endmodule
`default_nettype wire

// [sim/adcs_sequencer_properties.sv]
// Concurrent timing, interrupt-enable and read-idle checks of the conversion sequencer at its ports.
`timescale 1ns/10ps
`default_nettype none
module adcs_sequencer_properties
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic afe_sample,
    input wire logic afe_convert,
    input wire logic result_valid,
    input wire logic conversion_end_interrupt
);
    logic spd, scan, ie, fresh, clean;
    logic [7:0] tcnt, gap, scnt;
    wire logic csr_wr = wr && addr == 8'h00;
    // Shadow of the control bits and cycle counters since start, last result and sampling.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {spd, scan, ie, fresh, clean} <= 5'h00;
            tcnt <= 8'h00;
            gap <= 8'h00;
            scnt <= 8'h00;
        end
        else
        begin
            tcnt <= (csr_wr && wdata[6]) ? 8'h00 : tcnt + 8'h01;
            gap <= result_valid ? 8'h01 : gap + 8'h01;
            scnt <= afe_sample ? scnt + 8'h01 : 8'h00;
            if (csr_wr)
                {ie, scan, spd, fresh} <= {wdata[5:3], wdata[6]};
            else if (result_valid)
                fresh <= 1'b0;
            clean <= !wr && (clean || result_valid);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_sample_end;
        $fell(afe_sample) && (fresh || clean);
    endsequence
    property p_delay;
        $rose(afe_sample) && fresh && !result_valid |->
            (spd ? tcnt inside {[8'h04:8'h05]} : tcnt inside {[8'h06:8'h09]});
    endproperty
    property p_sample;
        s_sample_end |-> scnt == (spd ? 8'h0F : 8'h1F);
    endproperty
    property p_order;
        s_sample_end |-> afe_convert && !afe_sample;
    endproperty
    property p_total;
        result_valid && fresh |->
            (spd ? tcnt inside {[8'h45:8'h46]} : tcnt inside {[8'h83:8'h86]});
    endproperty
    property p_scan;
        result_valid && clean && scan |-> gap == (spd ? 8'h42 : 8'h80);
    endproperty
    property p_stored;
        result_valid |-> $past(afe_convert);
    endproperty
    property p_irq;
        $rose(conversion_end_interrupt) |-> ie;
    endproperty
    property p_rd_idle;
        !$past(rd) |-> rdata == 32'h0;
    endproperty
    a_delay: assert property (p_delay) else $error("start delay out of range");
    a_sample: assert property (p_sample) else $error("sampling length wrong");
    a_order: assert property (p_order) else $error("no conversion after sampling");
    a_total: assert property (p_total) else $error("conversion time out of range");
    a_scan: assert property (p_scan) else $error("scan repeat time wrong");
    a_stored: assert property (p_stored) else $error("result without conversion");
    a_irq: assert property (p_irq) else $error("end interrupt while disabled");
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle zero");
endmodule
`default_nettype wire

// [sim/adcs_afe_model.sv]
// Analog front end and external trigger source facing the sequencer.
`timescale 1ns/10ps
`default_nettype none
module adcs_afe_model
(
    input wire logic clk,
    input wire logic afe_sample,
    input wire logic afe_convert,
    input wire logic [2:0] afe_channel,
    input wire logic fire,
    output logic [9:0] afe_result,
    output logic external_trigger_pin
);
    logic [2:0] held = 3'h0;
    logic [3:0] low = 4'h0;
    initial afe_result = 10'h000;
    // Outside conversion the result lines toggle so a stale value is never seen.
    always @(posedge clk)
    begin
        if (afe_sample)
            held <= afe_channel;
        afe_result <= afe_convert ? {held, held, held, 1'b1} : ~afe_result;
        low <= fire ? 4'h4 : low - {3'h0, low != 4'h0};
    end
    assign external_trigger_pin = (low == 4'h0);
endmodule
`default_nettype wire

// [sim/adcs_sequencer_tb.sv]
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin $display("BAD %s exp %h got %h", n, e, g); fail_count++; end end
module adcs_sequencer_tb;
    logic clk = 0, reset_n = 0, wr = 0, rd = 0, fire = 0, sp;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic afe_sample, afe_convert, result_valid, conversion_end_interrupt, irq;
    logic external_trigger_pin;
    logic [2:0] afe_channel, result_channel, ch;
    logic [9:0] afe_result;
    logic [15:0] seed = 16'h2275;
    int i, n, cyc = 0, fail_count = 0, samples_checked = 0;
    adcs_sequencer u_dut (.*);
    adcs_afe_model u_afe (.*);
    always #5 clk = ~clk;
    function automatic logic [15:0] xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    function automatic logic [9:0] res_of(input logic [2:0] c);
        return {c, c, c, 1'b1};
    endfunction
    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata & m)
    endtask
    task automatic wait_rv(input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        while (result_valid !== 1'b1 && cnt < lim);
    endtask
    task automatic pulse_trig();
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(8'h04, 32'h7E, 32'hFF, "trg_reset");
        rd_chk(8'h14, 32'h0, 32'hFFFFFFFF, "unmapped");
        for (i = 0; i < 6; i++)
        begin
            ch = xs() % 8;
            sp = i[0];
            wr_reg(8'h00, {25'h0, 1'b1, 2'h0, sp, ch});
            wait_rv(200, n);
            `CHK("t_conv", 1'b1, sp ? (n >= 69 && n <= 70) : (n >= 131 && n <= 134))
            `CHK("res_ch", ch, result_channel)
            rd_chk(8'h10, {19'h0, ch, res_of(ch)}, 32'h1FFF, "result");
            rd_chk(8'h00, {24'h0, 4'h8, sp, ch}, 32'hFF, "csr_done");
            wr_reg(8'h00, 32'h0);
        end
        rd_chk(8'h08, 32'h1, 32'h1, "stat_clr");
        wr_reg(8'h0C, 32'h1);
        wr_reg(8'h00, 32'h68);
        wait_rv(200, n);
        repeat (3) @(posedge clk);
        #1;
        `CHK("irq_on", 1'b1, irq)
        `CHK("end_int", 1'b1, conversion_end_interrupt)
        rd_chk(8'h08, 32'h1, 32'h3, "stat_end");
        wr_reg(8'h00, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        `CHK("irq_off", 1'b0, irq)
        `CHK("int_off", 1'b0, conversion_end_interrupt)
        wr_reg(8'h0C, 32'h0);
        wr_reg(8'h04, 32'h0);
        pulse_trig();
        repeat (40) @(posedge clk);
        #1;
        `CHK("trg_off", 1'b0, afe_sample)
        rd_chk(8'h00, 32'h0, 32'hFF, "no_start");
        wr_reg(8'h04, 32'h80);
        pulse_trig();
        wait_rv(250, n);
        `CHK("trg_t", 1'b1, n >= 131 && n <= 145)
        `CHK("irq_mask", 1'b0, irq)
        rd_chk(8'h08, 32'h2, 32'h2, "stat_trig");
        wr_reg(8'h00, 32'h5D);
        for (i = 0; i < 3; i++)
        begin
            wait_rv(200, n);
            `CHK("scan_ch", 3'h4 + i[2:0] % 2, result_channel)
            `CHK("scan_t", 1'b1, i ? n == 66 : (n >= 69 && n <= 70))
        end
        wr_reg(8'h00, 32'h18);
        wait_rv(150, n);
        `CHK("scan_stop", 1'b0, result_valid)
        wr_reg(8'h00, 32'h56);
        for (i = 0; i < 4; i++)
        begin
            wait_rv(200, n);
            `CHK("scan0_ch", 3'h4 + i % 3, result_channel)
            `CHK("scan0_t", 1'b1, i ? n == 128 : (n >= 131 && n <= 134))
        end
        wr_reg(8'h00, 32'h0);
        report_and_stop();
    end
endmodule
bind adcs_sequencer adcs_sequencer_properties u_props (.*);
`default_nettype wire
